// >>> pkg/hcd_pkg.sv
// constants and types shared by the wait and bus cycle decoder core
// Notes on behaviour
// RQ1 - opcode 8F is wait: one byte, clears interrupt mask, halts, two or more cycles
// RQ2 - relative operand is a signed byte, -128..+127 from the next instruction
// RQ3 - direct operand is one byte; high address byte forced to zero
// RQ4 - bit number operand is 0..7 and selects one bit of the byte
// RQ5 - 8-bit index offset is unsigned added to index; 16-bit offset full width
// RQ6 - post-increment mode uses index as address, then increments the index
// RQ7 - stack 8-bit offset mode: address is stack pointer plus one byte
// RQ8 - stack 16-bit offset mode: address is stack pointer plus two bytes
// RQ9 - free cycle lasts one clock, needs no bus, and shows as a read
// RQ10 - program fetch reads next sequential byte and advances program counter
// RQ11 - push writes one stack byte, pop reads one, stack pointer follows
// RQ12 - vector read from top page, high byte first then low byte
// RQ13 - operand read or write moves exactly one byte
// RQ14 - prefix byte 9E selects the second opcode page for the next byte
// RQ15 - halted core resumes on unmasked interrupt via stacking and vector fetch
package hcd_pkg;
  // opcodes handled by this core
  localparam logic [7:0]  OPC_WAIT     = 8'h8F;
  localparam logic [7:0]  OPC_PAGE2    = 8'h9E;
  localparam logic [7:0]  OPC_BRANCH   = 8'h20;
  localparam logic [7:0]  OPC_CMP_PI   = 8'h71;
  localparam logic [7:0]  OPC_PULL_A   = 8'h86;
  localparam logic [7:0]  OPC_PUSH_A   = 8'h87;
  // accumulator family: low nibble picks load or store, high nibble the mode
  localparam logic [3:0]  LO_LOAD      = 4'h6;
  localparam logic [3:0]  LO_STORE     = 4'h7;
  localparam logic [3:0]  NIB_BITOP    = 4'h1;
  localparam logic [3:0]  NIB_IMM      = 4'hA;
  localparam logic [3:0]  NIB_DIR      = 4'hB;
  localparam logic [3:0]  NIB_EXT      = 4'hC;
  localparam logic [3:0]  NIB_OFF16    = 4'hD;
  localparam logic [3:0]  NIB_OFF8     = 4'hE;
  // vectors live in the top page
  localparam logic [7:0]  VEC_PAGE     = 8'hFF;
  localparam logic [15:0] VEC_RESET    = 16'hFFFE;
  localparam logic [15:0] VEC_IRQ      = 16'hFFFA;
  localparam logic [7:0]  ZERO_PAGE_HI = 8'h00;
  // reset values
  localparam logic [15:0] SP_RESET     = 16'h00FF;
  localparam logic [7:0]  FLAGS_RESET  = 8'h68;
  // condition flag bit positions
  localparam int          FLG_C        = 0;
  localparam int          FLG_Z        = 1;
  localparam int          FLG_N        = 2;
  localparam int          FLG_I        = 3;
  localparam int          FLG_V        = 7;
  // interrupt stacking pushes pcl, pch, x, a, flags
  localparam logic [2:0]  PUSH_LAST    = 3'h4;

  typedef enum logic [3:0] {
    MD_NONE, MD_IMMEDIATE, MD_DIRECT, MD_EXTENDED, MD_INDEXED, MD_INDEXED_OFF8,
    MD_INDEXED_OFF16, MD_INDEXED_POSTINC, MD_STACK_OFF8, MD_STACK_OFF16
  } hcd_mode_t;

  typedef enum logic [3:0] {
    OP_NOP, OP_LOAD, OP_STORE, OP_BIT_SET, OP_BIT_CLR, OP_BRANCH,
    OP_CMP_BRANCH, OP_PUSH, OP_PULL, OP_WAIT
  } hcd_op_t;

  typedef enum logic [2:0] {
    CYC_FREE, CYC_FETCH, CYC_READ, CYC_WRITE, CYC_PUSH, CYC_POP, CYC_VECTOR
  } hcd_cycle_t;

  typedef struct packed {
    hcd_op_t    op;
    hcd_mode_t  mode;
    logic [2:0] bitNum;
    logic [1:0] oprBytes;
  } hcd_decode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        write;
    hcd_cycle_t  cycle;
  } hcd_bus_t;
endpackage

// >>> src/hcd_op_decode.sv
// opcode decoder: instruction class, addressing mode and operand length
module hcd_op_decode (
  // opcode byte and page select
  input  wire logic [7:0]         opcode,
  input  wire logic               page2,
  // decoded instruction
  output hcd_pkg::hcd_decode_t    dec
);
  wire logic [3:0] hiNib   = opcode[7:4];
  wire logic [3:0] loNib   = opcode[3:0];
  wire logic       isLoad  = loNib == hcd_pkg::LO_LOAD;
  wire logic       isStore = loNib == hcd_pkg::LO_STORE;
  // second page only holds the stack offset forms of load and store
  wire logic       famPage2 = (hiNib == hcd_pkg::NIB_OFF16) || (hiNib == hcd_pkg::NIB_OFF8); // RQ14
  wire logic       famHiOk = page2 ? famPage2 : (hiNib >= hcd_pkg::NIB_IMM);
  wire logic       accFam  = famHiOk && (isLoad || (isStore && hiNib != hcd_pkg::NIB_IMM));
  wire logic       bitOp   = !page2 && hiNib == hcd_pkg::NIB_BITOP;
  wire logic       pg1     = !page2;

  // instruction class; unknown codes run as a one-cycle no-op
  wire hcd_pkg::hcd_op_t opSel =
    bitOp ? (opcode[0] ? hcd_pkg::OP_BIT_CLR : hcd_pkg::OP_BIT_SET) :
    accFam ? (isLoad ? hcd_pkg::OP_LOAD : hcd_pkg::OP_STORE) :
    (pg1 && opcode == hcd_pkg::OPC_BRANCH) ? hcd_pkg::OP_BRANCH :
    (pg1 && opcode == hcd_pkg::OPC_CMP_PI) ? hcd_pkg::OP_CMP_BRANCH :
    (pg1 && opcode == hcd_pkg::OPC_PUSH_A) ? hcd_pkg::OP_PUSH :
    (pg1 && opcode == hcd_pkg::OPC_PULL_A) ? hcd_pkg::OP_PULL :
    (pg1 && opcode == hcd_pkg::OPC_WAIT) ? hcd_pkg::OP_WAIT : hcd_pkg::OP_NOP; // RQ1

  // mode of the accumulator family from the high nibble
  wire hcd_pkg::hcd_mode_t modeAcc =
    hiNib == hcd_pkg::NIB_IMM ? hcd_pkg::MD_IMMEDIATE :
    hiNib == hcd_pkg::NIB_DIR ? hcd_pkg::MD_DIRECT :
    hiNib == hcd_pkg::NIB_EXT ? hcd_pkg::MD_EXTENDED :
    hiNib == hcd_pkg::NIB_OFF16 ? (page2 ? hcd_pkg::MD_STACK_OFF16 : hcd_pkg::MD_INDEXED_OFF16) : // RQ8
    hiNib == hcd_pkg::NIB_OFF8 ? (page2 ? hcd_pkg::MD_STACK_OFF8 : hcd_pkg::MD_INDEXED_OFF8) : // RQ7
    hcd_pkg::MD_INDEXED;

  wire hcd_pkg::hcd_mode_t modeSel =
    accFam ? modeAcc :
    bitOp ? hcd_pkg::MD_DIRECT :
    opSel == hcd_pkg::OP_CMP_BRANCH ? hcd_pkg::MD_INDEXED_POSTINC : hcd_pkg::MD_NONE; // RQ6

  // operand bytes after the opcode; a branch carries its one offset byte
  wire logic twoBytes = modeSel == hcd_pkg::MD_EXTENDED || modeSel == hcd_pkg::MD_INDEXED_OFF16 ||
                        modeSel == hcd_pkg::MD_STACK_OFF16;
  wire logic oneByte  = opSel == hcd_pkg::OP_BRANCH || opSel == hcd_pkg::OP_CMP_BRANCH ||
                        modeSel == hcd_pkg::MD_IMMEDIATE || modeSel == hcd_pkg::MD_DIRECT ||
                        modeSel == hcd_pkg::MD_INDEXED_OFF8 || modeSel == hcd_pkg::MD_STACK_OFF8;

  assign dec.op       = opSel;
  assign dec.mode     = modeSel;
  assign dec.bitNum   = opcode[3:1]; // RQ4
  assign dec.oprBytes = twoBytes ? 2'h2 : (oneByte ? 2'h1 : 2'h0);
endmodule

// >>> src/hcd_cpu_core.sv
// cpu bus cycle sequencer: fetch, operand modes, stack, vectors and wait
module hcd_cpu_core (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // system bus to program, data and stack memory
  output hcd_pkg::hcd_bus_t       busOut,
  input  wire logic [7:0]         busRdata,
  // interrupt request pin, asynchronous
  input  wire logic               irqPin,
  // status
  output logic                    halted,
  output logic                    intMask
);
  typedef enum logic [3:0] {
    ST_VEC_HI, ST_VEC_LO, ST_FETCH, ST_FETCH_P2, ST_OPR_HI, ST_OPR_LO, ST_READ,
    ST_WRITE, ST_BRANCH, ST_PUSH, ST_POP, ST_WAIT_FREE, ST_HALT, ST_INT_PUSH
  } hcd_state_t;

  hcd_state_t           state_reg, state_next;
  logic [15:0]          pc_reg, pc_next;
  logic [15:0]          sp_reg, sp_next;
  logic [15:0]          hx_reg, hx_next;
  logic [15:0]          opr_reg, opr_next;
  logic [7:0]           acc_reg, acc_next;
  logic [7:0]           condFlags_reg, condFlags_next;
  logic [7:0]           rdata_reg, rdata_next;
  logic [2:0]           pushCnt_reg, pushCnt_next;
  logic                 vecIrq_reg, vecIrq_next;
  logic                 irqMeta_reg, irqSync_reg;
  hcd_pkg::hcd_decode_t dec_reg, dec_next;
  hcd_pkg::hcd_decode_t decNow;

  // next state after the operand bytes; used after decode and after operands
  function automatic hcd_state_t execState(input hcd_pkg::hcd_decode_t d);
    hcd_state_t s;
    s = ST_FETCH;
    case (d.op)
      hcd_pkg::OP_LOAD: s = (d.mode == hcd_pkg::MD_IMMEDIATE) ? ST_FETCH : ST_READ;
      hcd_pkg::OP_STORE: s = ST_WRITE;
      hcd_pkg::OP_BIT_SET, hcd_pkg::OP_BIT_CLR, hcd_pkg::OP_CMP_BRANCH: s = ST_READ;
      hcd_pkg::OP_BRANCH: s = ST_BRANCH;
      hcd_pkg::OP_PUSH: s = ST_PUSH;
      hcd_pkg::OP_PULL: s = ST_POP;
      hcd_pkg::OP_WAIT: s = ST_WAIT_FREE;
      default: s = ST_FETCH;
    endcase
    return s;
  endfunction

  // state after an opcode byte, by number of operand bytes
  function automatic hcd_state_t afterOpcode(input hcd_pkg::hcd_decode_t d);
    return (d.oprBytes == 2'h2) ? ST_OPR_HI : (d.oprBytes == 2'h1) ? ST_OPR_LO : execState(d);
  endfunction

  // flag update of a load: n and z from data, v cleared
  function automatic logic [7:0] loadFlags(input logic [7:0] f, input logic [7:0] d);
    logic [7:0] r;
    r = f;
    r[hcd_pkg::FLG_N] = d[7];
    r[hcd_pkg::FLG_Z] = (d == 8'h00);
    r[hcd_pkg::FLG_V] = 1'b0;
    return r;
  endfunction

  // opcode decode straight off the read data during fetch
  hcd_op_decode u_decode (
    .opcode (busRdata),
    .page2  (state_reg == ST_FETCH_P2),
    .dec    (decNow)
  );

  // address arithmetic; one-byte operands leave opr_reg high byte at zero
  wire logic [15:0] off8    = {hcd_pkg::ZERO_PAGE_HI, opr_reg[7:0]}; // RQ3 RQ5
  wire logic [15:0] relOff  = {{8{opr_reg[7]}}, opr_reg[7:0]}; // RQ2
  wire logic [15:0] pcInc   = pc_reg + 16'h0001;
  wire logic [15:0] spInc   = sp_reg + 16'h0001;
  wire logic [15:0] spDec   = sp_reg - 16'h0001;
  wire logic [15:0] vecBase = vecIrq_reg ? hcd_pkg::VEC_IRQ : hcd_pkg::VEC_RESET;
  wire hcd_pkg::hcd_mode_t md = dec_reg.mode;
  wire logic [15:0] effAddr =
    md == hcd_pkg::MD_DIRECT ? off8 : // RQ3
    md == hcd_pkg::MD_EXTENDED ? opr_reg :
    md == hcd_pkg::MD_INDEXED_OFF8 ? hx_reg + off8 : // RQ5
    md == hcd_pkg::MD_INDEXED_OFF16 ? hx_reg + opr_reg : // RQ5
    md == hcd_pkg::MD_STACK_OFF8 ? sp_reg + off8 : // RQ7
    md == hcd_pkg::MD_STACK_OFF16 ? sp_reg + opr_reg : hx_reg; // RQ8 RQ6

  // interrupt is taken only between instructions and while unmasked
  wire logic intTake = irqSync_reg && !condFlags_reg[hcd_pkg::FLG_I];

  // write data: bit modify, store, and the interrupt stacking order
  wire logic [7:0]      bitMask = 8'h01 << dec_reg.bitNum; // RQ4
  wire logic [7:0]      modByte = (dec_reg.op == hcd_pkg::OP_BIT_SET) ? (rdata_reg | bitMask)
                                                                       : (rdata_reg & ~bitMask);
  wire logic            isBitOp = dec_reg.op == hcd_pkg::OP_BIT_SET || dec_reg.op == hcd_pkg::OP_BIT_CLR;
  wire logic [4:0][7:0] pushSeq = {condFlags_reg, acc_reg, hx_reg[7:0], pc_reg[15:8], pc_reg[7:0]};
  wire logic            stVec   = state_reg == ST_VEC_HI || state_reg == ST_VEC_LO;
  wire logic            stProg  = (state_reg == ST_FETCH && !intTake) || state_reg == ST_FETCH_P2 ||
                                  state_reg == ST_OPR_HI || state_reg == ST_OPR_LO;
  wire logic            stPush  = state_reg == ST_PUSH || state_reg == ST_INT_PUSH;

  // bus drive: free cycles present the program counter as a read
  assign busOut.cycle = stVec ? hcd_pkg::CYC_VECTOR : // RQ12
                        stProg ? hcd_pkg::CYC_FETCH : // RQ10
                        state_reg == ST_READ ? hcd_pkg::CYC_READ : // RQ13
                        state_reg == ST_WRITE ? hcd_pkg::CYC_WRITE : // RQ13
                        stPush ? hcd_pkg::CYC_PUSH : // RQ11
                        state_reg == ST_POP ? hcd_pkg::CYC_POP : hcd_pkg::CYC_FREE; // RQ9
  assign busOut.addr  = state_reg == ST_VEC_HI ? vecBase :
                        state_reg == ST_VEC_LO ? vecBase + 16'h0001 : // RQ12
                        (state_reg == ST_READ || state_reg == ST_WRITE) ? effAddr :
                        stPush ? sp_reg : // RQ11
                        state_reg == ST_POP ? spInc : pc_reg;
  assign busOut.wdata = state_reg == ST_INT_PUSH ? pushSeq[pushCnt_reg] :
                        (state_reg == ST_WRITE && isBitOp) ? modByte : acc_reg;
  assign busOut.write = state_reg == ST_WRITE || stPush; // RQ9
  assign halted       = state_reg == ST_HALT;
  assign intMask      = condFlags_reg[hcd_pkg::FLG_I];

  // sequencer next values
  always_comb begin
    state_next     = state_reg;
    pc_next        = pc_reg;
    sp_next        = sp_reg;
    hx_next        = hx_reg;
    opr_next       = opr_reg;
    acc_next       = acc_reg;
    condFlags_next = condFlags_reg;
    rdata_next     = rdata_reg;
    pushCnt_next   = pushCnt_reg;
    vecIrq_next    = vecIrq_reg;
    dec_next       = dec_reg;
    case (state_reg)
      ST_VEC_HI: begin
        pc_next    = {busRdata, pc_reg[7:0]}; // RQ12
        state_next = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        pc_next    = {pc_reg[15:8], busRdata};
        state_next = ST_FETCH;
      end
      ST_FETCH: begin
        if (intTake) begin
          vecIrq_next  = 1'b1;
          pushCnt_next = 3'h0;
          state_next   = ST_INT_PUSH;
        end else begin
          pc_next    = pcInc; // RQ10
          dec_next   = decNow;
          opr_next   = 16'h0000;
          state_next = (busRdata == hcd_pkg::OPC_PAGE2) ? ST_FETCH_P2 : afterOpcode(decNow); // RQ14
        end
      end
      ST_FETCH_P2: begin
        pc_next    = pcInc;
        dec_next   = decNow;
        state_next = afterOpcode(decNow); // RQ14
      end
      ST_OPR_HI: begin
        pc_next    = pcInc;
        opr_next   = {busRdata, opr_reg[7:0]}; // RQ8
        state_next = ST_OPR_LO;
      end
      ST_OPR_LO: begin
        pc_next    = pcInc;
        opr_next   = {opr_reg[15:8], busRdata};
        state_next = execState(dec_reg);
        if (dec_reg.op == hcd_pkg::OP_LOAD && dec_reg.mode == hcd_pkg::MD_IMMEDIATE) begin
          acc_next       = busRdata;
          condFlags_next = loadFlags(condFlags_reg, busRdata);
        end
      end
      ST_READ: begin
        rdata_next = busRdata; // RQ13
        state_next = isBitOp ? ST_WRITE : ST_FETCH;
        if (dec_reg.op == hcd_pkg::OP_LOAD) begin
          acc_next       = busRdata;
          condFlags_next = loadFlags(condFlags_reg, busRdata);
        end
        if (dec_reg.op == hcd_pkg::OP_CMP_BRANCH) begin
          hx_next    = hx_reg + 16'h0001; // RQ6
          state_next = (busRdata == acc_reg) ? ST_BRANCH : ST_FETCH;
        end
      end
      ST_BRANCH: begin
        pc_next    = pc_reg + relOff; // RQ2
        state_next = ST_FETCH;
      end
      ST_PUSH: begin
        sp_next    = spDec; // RQ11
        state_next = ST_FETCH;
      end
      ST_POP: begin
        sp_next    = spInc; // RQ11
        acc_next   = busRdata;
        state_next = ST_FETCH;
      end
      ST_WAIT_FREE: begin
        condFlags_next[hcd_pkg::FLG_I] = 1'b0; // RQ1
        state_next = ST_HALT;
      end
      ST_HALT: begin
        if (intTake) begin
          vecIrq_next  = 1'b1; // RQ15
          pushCnt_next = 3'h0;
          state_next   = ST_INT_PUSH;
        end
      end
      ST_INT_PUSH: begin
        sp_next      = spDec;
        pushCnt_next = pushCnt_reg + 3'h1;
        if (pushCnt_reg == hcd_pkg::PUSH_LAST) begin
          condFlags_next[hcd_pkg::FLG_I] = 1'b1;
          state_next = ST_VEC_HI; // RQ15
        end
      end
      default: state_next = ST_FETCH;
    endcase
  end

  // architectural and sequencer registers; reset starts with the reset vector
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg     <= ST_VEC_HI;
      pc_reg        <= 16'h0000;
      sp_reg        <= hcd_pkg::SP_RESET;
      hx_reg        <= 16'h0000;
      opr_reg       <= 16'h0000;
      acc_reg       <= 8'h00;
      condFlags_reg <= hcd_pkg::FLAGS_RESET;
      rdata_reg     <= 8'h00;
      pushCnt_reg   <= 3'h0;
      vecIrq_reg    <= 1'b0;
      dec_reg       <= '0;
    end else begin
      state_reg     <= state_next;
      pc_reg        <= pc_next;
      sp_reg        <= sp_next;
      hx_reg        <= hx_next;
      opr_reg       <= opr_next;
      acc_reg       <= acc_next;
      condFlags_reg <= condFlags_next;
      rdata_reg     <= rdata_next;
      pushCnt_reg   <= pushCnt_next;
      vecIrq_reg    <= vecIrq_next;
      dec_reg       <= dec_next;
    end
  end

  // two-stage synchroniser; only the second stage feeds logic
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irqMeta_reg <= 1'b0;
      irqSync_reg <= 1'b0;
    end else begin
      irqMeta_reg <= irqPin;
      irqSync_reg <= irqMeta_reg;
    end
  end

  // checks on the bus sequencing
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  wait_halt_a: assert property ((state_reg == ST_FETCH && !intTake && busRdata == hcd_pkg::OPC_WAIT) |=> // RQ1
    state_reg == ST_WAIT_FREE ##1 (halted && !intMask)) else $error("wait did not halt");
  rel_target_a: assert property (state_reg == ST_BRANCH |=> // RQ2
    pc_reg == $past(pc_reg) + {{8{$past(opr_reg[7])}}, $past(opr_reg[7:0])}) else $error("bad branch target");
  direct_page_a: assert property ((state_reg inside {ST_READ, ST_WRITE} && md == hcd_pkg::MD_DIRECT) |-> // RQ3
    busOut.addr[15:8] == hcd_pkg::ZERO_PAGE_HI) else $error("direct access left page zero");
  bit_select_a: assert property ((state_reg == ST_WRITE && isBitOp) |-> // RQ4
    ((busOut.wdata ^ rdata_reg) & ~bitMask) == 8'h00 &&
    busOut.wdata[dec_reg.bitNum] == (dec_reg.op == hcd_pkg::OP_BIT_SET)) else $error("bit op touched wrong bit");
  index_off8_a: assert property ((state_reg == ST_READ && md == hcd_pkg::MD_INDEXED_OFF8) |-> // RQ5
    busOut.addr == hx_reg + {8'h00, opr_reg[7:0]}) else $error("bad indexed 8-bit address");
  post_inc_a: assert property ((state_reg == ST_READ && md == hcd_pkg::MD_INDEXED_POSTINC) |-> // RQ6
    busOut.addr == hx_reg ##1 hx_reg == $past(hx_reg) + 16'h0001) else $error("post increment wrong");
  stack_off8_a: assert property ((state_reg inside {ST_READ, ST_WRITE} && md == hcd_pkg::MD_STACK_OFF8) |-> // RQ7
    busOut.addr == sp_reg + {8'h00, opr_reg[7:0]}) else $error("bad stack 8-bit address");
  stack_off16_a: assert property ((state_reg inside {ST_READ, ST_WRITE} && md == hcd_pkg::MD_STACK_OFF16) |-> // RQ8
    busOut.addr == sp_reg + opr_reg) else $error("bad stack 16-bit address");
  free_read_a: assert property (busOut.cycle == hcd_pkg::CYC_FREE |-> !busOut.write) else $error("free cycle wrote"); // RQ9
  fetch_adv_a: assert property (busOut.cycle == hcd_pkg::CYC_FETCH |-> busOut.addr == pc_reg ##1 // RQ10
    pc_reg == $past(pc_reg) + 16'h0001) else $error("fetch did not advance");
  push_sp_a: assert property (busOut.cycle == hcd_pkg::CYC_PUSH |-> (busOut.write && busOut.addr == sp_reg) ##1 // RQ11
    sp_reg == $past(sp_reg) - 16'h0001) else $error("push stack pointer wrong");
  pop_sp_a: assert property (busOut.cycle == hcd_pkg::CYC_POP |-> !busOut.write ##1 // RQ11
    (sp_reg == $past(sp_reg) + 16'h0001 && acc_reg == $past(busRdata))) else $error("pop wrong");
  vec_order_a: assert property (state_reg == ST_VEC_HI |-> busOut.addr[15:8] == hcd_pkg::VEC_PAGE ##1 // RQ12
    (busOut.cycle == hcd_pkg::CYC_VECTOR && busOut.addr == $past(busOut.addr) + 16'h0001) ##1
    pc_reg == {$past(busRdata, 2), $past(busRdata)}) else $error("vector order wrong");
  one_byte_a: assert property (state_reg == ST_WRITE |=> state_reg == ST_FETCH) else $error("write not one byte"); // RQ13
  page2_a: assert property ((state_reg == ST_FETCH && !intTake && busRdata == hcd_pkg::OPC_PAGE2) |=> // RQ14
    (state_reg == ST_FETCH_P2 && busOut.cycle == hcd_pkg::CYC_FETCH)) else $error("prefix not followed");
  wake_up_a: assert property ((state_reg == ST_HALT && irqSync_reg) |=> // RQ15
    busOut.cycle == hcd_pkg::CYC_PUSH [*5] ##1 busOut.cycle == hcd_pkg::CYC_VECTOR) else $error("no wake");
endmodule

// >>> tb/hcd_mem_model.sv
// memory model on the core's system bus: program, data and stack in one array
module hcd_mem_model (
  // clock
  input  wire logic              clk,
  // bus from the core and read data back
  input  wire hcd_pkg::hcd_bus_t busIn,
  output logic [7:0]             rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] memArr [0:65535];
  // empty memory holds an unused code so stray fetches run as one-byte no-ops
  initial for (int i = 0; i < 65536; i++) memArr[i] = 8'h9D;
  // no wait states: data answers in the cycle of its address
  assign rdata = memArr[busIn.addr];
  // write lands at the edge that ends the cycle; blocking, as the bench also loads this array
  always @(posedge clk) if (busIn.write) memArr[busIn.addr] = busIn.wdata;
endmodule

// >>> tb/cpu_wait_and_bus_cycle_decode_test.sv
// self-checking bench: cycle order, addressing modes, stack, vectors and wait
module cpu_wait_and_bus_cycle_decode_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam hcd_pkg::hcd_cycle_t CN = hcd_pkg::CYC_FREE;
  localparam hcd_pkg::hcd_cycle_t CF = hcd_pkg::CYC_FETCH;
  localparam hcd_pkg::hcd_cycle_t CR = hcd_pkg::CYC_READ;
  localparam hcd_pkg::hcd_cycle_t CW = hcd_pkg::CYC_WRITE;
  localparam hcd_pkg::hcd_cycle_t CP = hcd_pkg::CYC_PUSH;
  localparam hcd_pkg::hcd_cycle_t CU = hcd_pkg::CYC_POP;
  localparam hcd_pkg::hcd_cycle_t CV = hcd_pkg::CYC_VECTOR;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic              irqPin = 1'b0;
  logic [7:0]        busRdata;
  logic              halted;
  logic              intMask;
  hcd_pkg::hcd_bus_t busOut;
  int                miscompares = 0;
  int                checkCount = 0;

  // 50 MHz bus clock
  always #10 clk = ~clk;

  // core and the memory behind its bus
  hcd_cpu_core dut (.clk(clk), .resetn(resetn), .busOut(busOut), .busRdata(busRdata),
                    .irqPin(irqPin), .halted(halted), .intMask(intMask));
  hcd_mem_model mem (.clk(clk), .busIn(busOut), .rdata(busRdata));

  // comparison, verdict and bus cycle helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // free cycles carry no address of interest, so only kind and direction are compared
  task automatic cur(input hcd_pkg::hcd_cycle_t c, input logic [15:0] a, input logic w);
    check(16'(busOut.cycle), 16'(c));
    check(16'(busOut.write), 16'(w));
    if (c != CN) check(busOut.addr, a);
  endtask
  task automatic step(input hcd_pkg::hcd_cycle_t c, input logic [15:0] a, input logic w);
    @(negedge clk);
    cur(c, a, w);
  endtask
  task automatic fetch(input logic [15:0] a, input int n);
    for (int i = 0; i < n; i++) step(CF, a + 16'(i), 1'b0);
  endtask
  task automatic wd(input logic [7:0] v);
    check(16'(busOut.wdata), 16'(v));
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] q[$]);
    foreach (q[i]) mem.memArr[a + 16'(i)] = q[i];
  endtask
  // reset for four cycles; the vector then points at 0100
  task automatic reset_core();
    resetn = 1'b0;
    put(16'hFFFE, '{8'h01, 8'h00});
    repeat (4) @(negedge clk);
    cur(CV, 16'hFFFE, 1'b0);
    resetn = 1'b1;
    step(CV, 16'hFFFF, 1'b0);
  endtask

  // page-two stack modes, unsigned and wide index offsets, direct store
  task automatic s_modes();
    put(16'h0100, '{8'hA6, 8'h80, 8'h9E, 8'hE6, 8'h20, 8'h9E, 8'hD6, 8'h01, 8'h00,
                    8'hE6, 8'hFF, 8'hD6, 8'h12, 8'h34, 8'hB7, 8'h40});
    put(16'h1234, '{8'hA5});
    reset_core();
    fetch(16'h0100, 5);
    step(CR, 16'h011F, 1'b0);
    fetch(16'h0105, 4);
    step(CR, 16'h01FF, 1'b0);
    fetch(16'h0109, 2);
    step(CR, 16'h00FF, 1'b0);
    fetch(16'h010B, 3);
    step(CR, 16'h1234, 1'b0);
    fetch(16'h010E, 2);
    step(CW, 16'h0040, 1'b1);
    wd(8'hA5);
    fetch(16'h0110, 1);
  endtask

  // bit number 2 set, bit number 7 cleared
  task automatic s_bits();
    put(16'h0100, '{8'h14, 8'h40, 8'h1F, 8'h41});
    put(16'h0040, '{8'h00, 8'hFF});
    reset_core();
    fetch(16'h0100, 2);
    step(CR, 16'h0040, 1'b0);
    step(CW, 16'h0040, 1'b1);
    wd(8'h04);
    fetch(16'h0102, 2);
    step(CR, 16'h0041, 1'b0);
    step(CW, 16'h0041, 1'b1);
    wd(8'h7F);
  endtask

  // branches to both ends of the offset range, each with one free cycle
  task automatic s_branch();
    put(16'h0100, '{8'h20, 8'h80});
    put(16'h0082, '{8'h20, 8'h7F});
    reset_core();
    fetch(16'h0100, 2);
    step(CN, 16'h0000, 1'b0);
    fetch(16'h0082, 2);
    step(CN, 16'h0000, 1'b0);
    fetch(16'h0103, 1);
  endtask

  // compare at index: unequal falls through, equal branches after a free cycle;
  // each compare moves the index on, so the plain indexed read sees index plus two
  task automatic s_postinc();
    put(16'h0000, '{8'h55, 8'h00});
    put(16'h0100, '{8'h71, 8'h10, 8'h71, 8'h02});
    put(16'h0106, '{8'hF6});
    reset_core();
    fetch(16'h0100, 2);
    step(CR, 16'h0000, 1'b0);
    fetch(16'h0102, 2);
    step(CR, 16'h0001, 1'b0);
    step(CN, 16'h0000, 1'b0);
    fetch(16'h0106, 1);
    step(CR, 16'h0002, 1'b0);
  endtask

  // push, pop, push again at the same stack place
  task automatic s_stack();
    put(16'h0100, '{8'hA6, 8'h5A, 8'h87, 8'h86, 8'h87});
    reset_core();
    fetch(16'h0100, 3);
    step(CP, 16'h00FF, 1'b1);
    wd(8'h5A);
    fetch(16'h0103, 1);
    step(CU, 16'h00FF, 1'b0);
    fetch(16'h0104, 1);
    step(CP, 16'h00FF, 1'b1);
    wd(8'h5A);
  endtask

  // wait halts with the mask clear; a request resumes through stacking and vector
  task automatic s_wait();
    put(16'h0100, '{8'h8F});
    put(16'hFFFA, '{8'h02, 8'h00});
    reset_core();
    check(16'(intMask), 16'h0001);
    fetch(16'h0100, 1);
    step(CN, 16'h0000, 1'b0);
    repeat (3) step(CN, 16'h0000, 1'b0);
    check(16'(halted), 16'h0001);
    check(16'(intMask), 16'h0000);
    irqPin = 1'b1;
    for (int i = 0; i < 8 && busOut.cycle !== CP; i++) @(negedge clk);
    if (busOut.cycle !== CP) begin
      miscompares++;
      final_report();
    end
    cur(CP, 16'h00FF, 1'b1);
    wd(8'h01);
    irqPin = 1'b0;
    step(CP, 16'h00FE, 1'b1);
    wd(8'h01);
    for (int i = 2; i < 5; i++) step(CP, 16'h00FF - 16'(i), 1'b1);
    step(CV, 16'hFFFA, 1'b0);
    step(CV, 16'hFFFB, 1'b0);
    check(16'(intMask), 16'h0001);
    fetch(16'h0200, 1);
    check(16'(halted), 16'h0000);
  endtask

  // main sequence
  initial begin
    @(negedge clk);
    s_modes();
    s_bits();
    s_branch();
    s_postinc();
    s_stack();
    s_wait();
    final_report();
  end
endmodule
